//--- spseq_ctrl.sv
// Controller end: paced step clock and mode pins
`timescale 1ns/1ps
module spseq_ctrl (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   spseq_if.ctrl           pins,
   input  wire logic       cmd_step,
   input  wire logic       cmd_dir,
   input  wire logic       cmd_half,
   input  wire logic       cmd_both,
   input  wire logic       cmd_enable,
   input  wire logic       cmd_reset,
   output logic            busy,
   output logic            fault_seen,
   output logic [1:0]      fault_kind
);
   // Step phases: one timer paces hold, high, low
   typedef enum logic [1:0] {SPC_IDLE, SPC_HIGH, SPC_LOW, SPC_RST} spseq_ctrl_st_t;
   typedef struct packed {
      spseq_ctrl_st_t               st;
      logic [spseq_pkg::TIMER_W-1:0] tmr;
      logic                         sclk;
      logic                         half;
      logic                         both;
      logic                         dir;
      logic                         en;
      logic                         rstl;
      logic                         busy;
      logic                         fseen;
      logic [1:0]                   fkind;
   } spseq_ctrl_state_t;

   spseq_ctrl_state_t s_ff;
   spseq_ctrl_state_t nxt_s;

   function automatic logic [spseq_pkg::TIMER_W-1:0] spseq_cyc(input int c);
      spseq_cyc = spseq_pkg::TIMER_W'(c);
   endfunction

   always_comb begin
      nxt_s = s_ff;
      nxt_s.fseen = !pins.fault_flag_low;
      nxt_s.fkind = pins.fault_type_level;
      if (s_ff.tmr != '0) begin
         nxt_s.tmr = s_ff.tmr - 1'b1;
      end
      case (s_ff.st)
         SPC_IDLE: begin
            nxt_s.en = cmd_enable;
            if (cmd_reset) begin
               nxt_s.rstl = 1'b0;
               nxt_s.st = SPC_RST;
               nxt_s.tmr = spseq_cyc(spseq_pkg::RESET_WAIT_CYC);
            end else if (cmd_step && s_ff.tmr == '0) begin
               // Mode pins only change this far from any edge; enable follows cmd_enable at any time in SPC_IDLE
               nxt_s.half = cmd_half;
               nxt_s.both = cmd_both;
               nxt_s.dir = cmd_dir;
               nxt_s.st = SPC_HIGH;
               nxt_s.tmr = spseq_cyc(spseq_pkg::DIR_HOLD_CYC);
            end
         end
         SPC_HIGH: begin
            if (s_ff.tmr == '0 && !s_ff.sclk) begin
               nxt_s.sclk = 1'b1;
               // Equal high/low halves; the hold phases add low time, so duty stays below 50 percent
               nxt_s.tmr = spseq_cyc(s_ff.both ? spseq_pkg::PULSE_BOTH_CYC
                                               : spseq_pkg::PULSE_ONE_CYC);
            end else if (s_ff.tmr == '0) begin
               nxt_s.st = SPC_LOW;
               nxt_s.sclk = 1'b0;
               nxt_s.tmr = spseq_cyc(s_ff.both ? spseq_pkg::PULSE_BOTH_CYC
                                               : spseq_pkg::PULSE_ONE_CYC);
            end
         end
         SPC_LOW: begin
            if (s_ff.tmr == '0) begin
               nxt_s.st = SPC_IDLE;
               // Hold after the last edge before modes may move; ramp is the caller's
               nxt_s.tmr = spseq_cyc(spseq_pkg::DIR_HOLD_CYC);
            end
         end
         SPC_RST: begin
            nxt_s.rstl = 1'b1;
            if (s_ff.tmr == '0) begin
               nxt_s.st = SPC_IDLE;
            end
         end
         default: nxt_s.st = SPC_IDLE;
      endcase
      nxt_s.busy = (nxt_s.st != SPC_IDLE) || (nxt_s.tmr != '0);
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_ff <= '{st: SPC_IDLE, rstl: 1'b1, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign pins.step_clock        = s_ff.sclk;
   assign pins.excitation_select = s_ff.half;
   assign pins.edge_select       = !s_ff.both;
   assign pins.direction_select  = s_ff.dir;
   assign pins.system_reset_low  = s_ff.rstl;
   assign pins.enable            = s_ff.en;
   assign busy                   = s_ff.busy;
   assign fault_seen             = s_ff.fseen;
   assign fault_kind             = s_ff.fkind;
endmodule // spseq_ctrl

//--- spseq_device.sv
// Device end: phase sequencer with latched fault protection
//
// Functional notes
// - Low selects full-step, high selects half-step
// - Edge select high: rising only; low: both
// - Controller keeps modes still near clock edges
// - Controller limits step clock frequency
// - Controller keeps minimum step pulse width
// - Duty 40-50 percent, both edges; controller gives at most about 38 percent, holds lengthen low
// - Direction low clockwise, high counterclockwise
// - Controller holds direction around each edge
// - Internal reset: power-on plus external reset
// - Reset release starts at one-pos two-neg
// - Enable low forces all windings off
// - Enable low freezes all internal state; overcurrent and overheat latches still set while disabled
// - Enable high resumes the held phase
// - Step period ramp is left to the caller; controller does not ramp
// - Any latched fault pulls flag low
// - Fault type encoded on three-level output
// - Faults latch and keep windings off
// - Only reset or power cycle clears faults
// - Controller waits after reset before stepping
// - Controller holds enable low at power-up
// - No flyback in PWM off means open
`timescale 1ns/1ps
module spseq_device (
   input  wire logic    clk_sys,
   input  wire logic    reset,
   spseq_if.device      pins,
   input  wire logic    pwm_off_window,
   input  wire logic    flyback_seen,
   input  wire logic    overcurrent_trip,
   input  wire logic    overheat_trip
);
   typedef struct packed {
      logic [2:0]              pos;
      logic                    clk_prev;
      logic                    rst_prev;
      logic                    open_ff;
      logic                    oc_ff;
      logic                    oh_ff;
      logic [3:0]              drive;
      logic                    flag_oe_n;
      spseq_pkg::spseq_fault_t ftype;
   } spseq_dev_state_t;

   spseq_dev_state_t st_ff;
   spseq_dev_state_t nxt_st;

   // Half-step position to winding pattern {1p,1n,2p,2n}
   function automatic logic [3:0] spseq_pattern(input logic [2:0] p);
      case (p)
         3'h0:    spseq_pattern = 4'h8;
         3'h1:    spseq_pattern = 4'h9;
         3'h2:    spseq_pattern = 4'h1;
         3'h3:    spseq_pattern = 4'h5;
         3'h4:    spseq_pattern = 4'h4;
         3'h5:    spseq_pattern = 4'h6;
         3'h6:    spseq_pattern = 4'h2;
         3'h7:    spseq_pattern = 4'ha;
         default: spseq_pattern = 4'h0;
      endcase
   endfunction

   logic sys_rst;
   logic step_edge;
   logic any_fault;
   logic [2:0] step_size;

   always_comb begin
      // Power-on reset arrives as reset; both clear everything
      sys_rst = reset || !pins.system_reset_low;
      step_edge = pins.edge_select ? (pins.step_clock && !st_ff.clk_prev)
                                   : (pins.step_clock != st_ff.clk_prev);
      // Full-step keeps odd positions; half-step moves one; entry from half snaps forward
      if (pins.excitation_select) begin
         step_size = 3'h1;
      end else begin
         step_size = st_ff.pos[0] ? 3'h2 : 3'h1;
      end
      nxt_st = st_ff;
      if (sys_rst) begin
         nxt_st = '0;
         nxt_st.pos = spseq_pkg::POS_RESET;
         nxt_st.clk_prev = pins.step_clock;
         nxt_st.flag_oe_n = 1'b1;
      end else begin
         // Overcurrent and overheat latch regardless, open only while enabled; stepping frozen while disabled
         if (pwm_off_window && !flyback_seen && pins.enable) begin
            nxt_st.open_ff = 1'b1;
         end
         if (overcurrent_trip) begin
            nxt_st.oc_ff = 1'b1;
         end
         if (overheat_trip) begin
            nxt_st.oh_ff = 1'b1;
         end
         if (pins.enable) begin
            nxt_st.clk_prev = pins.step_clock;
            if (step_edge) begin
               if (pins.direction_select) begin
                  nxt_st.pos = st_ff.pos - step_size;
               end else begin
                  nxt_st.pos = st_ff.pos + step_size;
               end
            end
         end
      end
      any_fault = nxt_st.open_ff || nxt_st.oc_ff || nxt_st.oh_ff;
      // Windings show held position again on enable return
      if (!pins.enable || any_fault || sys_rst) begin
         nxt_st.drive = 4'h0;
      end else begin
         nxt_st.drive = spseq_pattern(nxt_st.pos);
      end
      nxt_st.flag_oe_n = !any_fault;
      // Overheat outranks overcurrent outranks open terminal
      if (nxt_st.oh_ff) begin
         nxt_st.ftype = spseq_pkg::SPSEQ_FT_OVERHEAT;
      end else if (nxt_st.oc_ff) begin
         nxt_st.ftype = spseq_pkg::SPSEQ_FT_OVERCURRENT;
      end else if (nxt_st.open_ff) begin
         nxt_st.ftype = spseq_pkg::SPSEQ_FT_OPEN;
      end else begin
         nxt_st.ftype = spseq_pkg::SPSEQ_FT_NONE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         // Whole-word clear first so the enum field needs no cast
         st_ff           <= '0;
         st_ff.pos       <= spseq_pkg::POS_RESET;
         st_ff.flag_oe_n <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pins.winding_one_pos     = st_ff.drive[3];
   assign pins.winding_one_neg     = st_ff.drive[2];
   assign pins.winding_two_pos     = st_ff.drive[1];
   assign pins.winding_two_neg     = st_ff.drive[0];
   assign pins.fault_flag_low_o    = 1'b0;
   assign pins.fault_flag_low_oe_n = st_ff.flag_oe_n;
   assign pins.fault_type_level    = st_ff.ftype;
endmodule // spseq_device

//--- spseq_if.sv
// Pins between the motion controller and the phase sequencer
`timescale 1ns/1ps
interface spseq_if;
   logic                      step_clock;
   logic                      excitation_select;
   logic                      edge_select;
   logic                      direction_select;
   logic                      system_reset_low;
   logic                      enable;
   logic                      winding_one_pos;
   logic                      winding_one_neg;
   logic                      winding_two_pos;
   logic                      winding_two_neg;
   logic                      fault_flag_low_o;
   logic                      fault_flag_low_oe_n;
   spseq_pkg::spseq_fault_t   fault_type_level;
   // Open-drain wire with pull-up: low only while driven
   wire fault_flag_low = (!fault_flag_low_oe_n) ? fault_flag_low_o : 1'b1;
   modport device (
      input  step_clock, excitation_select, edge_select, direction_select, system_reset_low, enable,
      output winding_one_pos, winding_one_neg, winding_two_pos, winding_two_neg,
      output fault_flag_low_o, fault_flag_low_oe_n, fault_type_level
   );
   modport ctrl (
      output step_clock, excitation_select, edge_select, direction_select, system_reset_low, enable,
      input  winding_one_pos, winding_one_neg, winding_two_pos, winding_two_neg,
      input  fault_flag_low, fault_type_level
   );
endinterface

//--- spseq_pkg.sv
// Shared constants and types of the stepper phase sequencer
package spseq_pkg;
   // Sequencer position: eight half-step positions, odd ones are full-step pairs
   localparam logic [2:0] POS_RESET      = 3'h1;  // One-positive and two-negative excited
   localparam int         SYS_CLK_HZ     = 50000000;
   localparam int         MODE_HOLD_NS   = 5000;
   localparam int         DIR_HOLD_NS    = 6250;
   localparam int         RESET_WAIT_NS  = 10000;
   localparam int         PULSE_BOTH_NS  = 20000;
   localparam int         PULSE_ONE_NS   = 10000;
   localparam int         NS_PER_S       = 1000000000;
   localparam int         CLK_NS         = NS_PER_S / SYS_CLK_HZ;
   localparam int         MODE_HOLD_CYC  = (MODE_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int         DIR_HOLD_CYC   = (DIR_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int         RESET_WAIT_CYC = (RESET_WAIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int         PULSE_BOTH_CYC = (PULSE_BOTH_NS + CLK_NS - 1) / CLK_NS;
   localparam int         PULSE_ONE_CYC  = (PULSE_ONE_NS + CLK_NS - 1) / CLK_NS;
   localparam int         TIMER_W        = 12;
   // Three-level fault type code
   typedef enum logic [1:0] {
      SPSEQ_FT_NONE,
      SPSEQ_FT_OPEN,
      SPSEQ_FT_OVERCURRENT,
      SPSEQ_FT_OVERHEAT
   } spseq_fault_t;
endpackage

//--- spseq_properties.sv
// Pin-level checks of the stepper phase sequencer
`timescale 1ns/1ps
module spseq_properties (
   input logic                    clk_sys,
   input logic                    reset,
   input logic                    step_clock,
   input logic                    excitation_select,
   input logic                    edge_select,
   input logic                    system_reset_low,
   input logic                    enable,
   input logic                    winding_one_pos,
   input logic                    winding_one_neg,
   input logic                    winding_two_pos,
   input logic                    winding_two_neg,
   input logic                    fault_flag_low,
   input spseq_pkg::spseq_fault_t fault_type_level
);
   logic [3:0] w;
   logic       ok;
   assign w  = {winding_one_pos, winding_one_neg, winding_two_pos, winding_two_neg};
   // Steps only count while running and fault free
   assign ok = enable && system_reset_low && fault_flag_low;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   off_disabled_a: assert property (!enable |=> w == 4'h0)
      else $error("on while disabled");
   off_faulted_a: assert property (!fault_flag_low && system_reset_low |=> w == 4'h0)
      else $error("on while faulted");
   flag_type_a: assert property (fault_flag_low == (fault_type_level == spseq_pkg::SPSEQ_FT_NONE))
      else $error("flag and type differ");
   reset_clear_a: assert property (!system_reset_low |=> fault_type_level == spseq_pkg::SPSEQ_FT_NONE)
      else $error("fault not cleared");
   start_phase_a: assert property ($rose(system_reset_low) && enable && fault_flag_low |=> w == 4'h9)
      else $error("wrong start phase");
   steady_out_a: assert property ((ok && $stable(step_clock)) [*3] |-> $stable(w))
      else $error("moved without step");
   rise_step_a: assert property (ok && $rose(step_clock) |-> ##[1:2] !$stable(w))
      else $error("no step on rise");
   fall_step_a: assert property (ok && !edge_select && $fell(step_clock) |-> ##[1:2] !$stable(w))
      else $error("no step on fall");
   full_pair_a: assert property (ok && !excitation_select && $rose(step_clock) |-> ##2 $countones(w) == 2)
      else $error("full step lost pair");
endmodule // spseq_properties

//--- stepper_phase_sequencer_tb.sv
// Bench joining the controller and device ends of the stepper sequencer
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module stepper_phase_sequencer_tb;
   // Winding pattern {1p,1n,2p,2n} of half-step positions 7 down to 0
   localparam logic [31:0] PATS = 32'ha2645198;
   logic       clk_sys = 1'h0, reset = 1'h1, last_clk = 1'h0, busy, fault_seen;
   logic       pwm_off_window = 1'h0, flyback_seen = 1'h1, overcurrent_trip = 1'h0, overheat_trip = 1'h0;
   logic       cmd_step = 1'h0, cmd_dir = 1'h0, cmd_half = 1'h0, cmd_both = 1'h0, cmd_enable = 1'h0, cmd_reset = 1'h0;
   logic [1:0] fault_kind;
   int         fail_count = 0, n_compared = 0, edges = 0, cycles = 0, pos = 1;
   spseq_if ifc ();
   spseq_ctrl i_spseq_ctrl (.clk_sys, .reset, .pins(ifc.ctrl), .cmd_step, .cmd_dir, .cmd_half, .cmd_both,
      .cmd_enable, .cmd_reset, .busy, .fault_seen, .fault_kind);
   spseq_device i_spseq_device (.clk_sys, .reset, .pins(ifc.device), .pwm_off_window, .flyback_seen,
      .overcurrent_trip, .overheat_trip);
   spseq_properties i_spseq_properties (.clk_sys, .reset, .step_clock(ifc.step_clock),
      .excitation_select(ifc.excitation_select), .edge_select(ifc.edge_select), .enable(ifc.enable),
      .system_reset_low(ifc.system_reset_low), .winding_one_pos(ifc.winding_one_pos),
      .winding_one_neg(ifc.winding_one_neg), .winding_two_pos(ifc.winding_two_pos),
      .winding_two_neg(ifc.winding_two_neg), .fault_flag_low(ifc.fault_flag_low),
      .fault_type_level(ifc.fault_type_level));
   wire [3:0] win = {ifc.winding_one_pos, ifc.winding_one_neg, ifc.winding_two_pos, ifc.winding_two_neg};
   always #10 clk_sys = ~clk_sys;
   // Counts step edges; while disabled the device keeps its old clock level
   always @(posedge clk_sys) begin
      if (++cycles == 80000) begin
         fail_count++;
         conclude();
      end else if (ifc.enable === 1'h1 && ifc.step_clock !== last_clk) begin
         edges += (ifc.step_clock === 1'h1 || ifc.edge_select === 1'h0);
         last_clk = ifc.step_clock;
      end
   end
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic do_step();
      edges = 0;
      cmd_step = 1'h1;
      tick();
      cmd_step = 1'h0;
      for (int n = 0; busy !== 1'h0 && n < 5000; n++)
         tick();
      repeat (4) tick();
      // A full step from a half position lands on the next pair first
      repeat (edges)
         pos = (pos + (cmd_dir ? -1 : 1) * ((cmd_half || pos[0] == 1'h0) ? 1 : 2)) & 7;
      `CHK("winding", cmd_enable ? PATS[4*pos +: 4] : 4'h0, win)
   endtask
   task automatic t_start();
      `CHK("winding", 4'h0, win)
      cmd_enable = 1'h1;
      repeat (4) tick();
      `CHK("winding", 4'h9, win)
      $display("start done");
   endtask
   task automatic t_walk();
      repeat (2) do_step();
      cmd_dir = 1'h1;
      repeat (2) do_step();
      cmd_half = 1'h1;
      repeat (3) do_step();
      {cmd_dir, cmd_half} = 2'h0;
      do_step();
      {cmd_both, cmd_half} = 2'h3;
      repeat (2) do_step();
      {cmd_both, cmd_half} = 2'h0;
      $display("mode walk done");
   endtask
   task automatic t_freeze();
      cmd_enable = 1'h0;
      repeat (4) tick();
      do_step();
      cmd_enable = 1'h1;
      repeat (4) tick();
      `CHK("winding", PATS[4*pos +: 4], win)
      $display("freeze done");
   endtask
   task automatic t_fault();
      for (int k = 1; k < 4; k++) begin
         {pwm_off_window, flyback_seen, overcurrent_trip, overheat_trip} = {k == 1, k != 1, k == 2, k == 3};
         repeat (3) tick();
         {pwm_off_window, flyback_seen, overcurrent_trip, overheat_trip} = 4'h4;
         repeat (4) tick();
         `CHK("flag", 1'h0, ifc.fault_flag_low)
         `CHK("type", k[1:0], ifc.fault_type_level)
         `CHK("kind", k[1:0], fault_kind)
         `CHK("seen", 1'h1, fault_seen)
         `CHK("winding", 4'h0, win)
         cmd_reset = 1'h1;
         repeat (3) tick();
         cmd_reset = 1'h0;
         repeat (spseq_pkg::RESET_WAIT_CYC + 20) tick();
         pos = 1;
         `CHK("winding", 4'h9, win)
      end
      do_step();
      $display("fault latch done");
   endtask
   initial begin
      repeat (6) tick();
      reset = 1'h0;
      t_start();
      t_walk();
      t_freeze();
      t_fault();
      conclude();
   end
endmodule // stepper_phase_sequencer_tb
